/* shared/dvfc_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef DVFC_MAP_SVH
`define DVFC_MAP_SVH
`define DVFC_WINCTL_ADDR 32'hc0000086
`define DVFC_CTLWORD_OFS 4'h8
`define DVFC_WINCTL_RESET 64'h0000000000000000
`define DVFC_WIN_BASE_HI 15
`define DVFC_WIN_BASE_LO 4
`define DVFC_MARKER_BIT 1
`define DVFC_ENABLE_BIT 0
`define DVFC_WINCTL_WMASK 64'h000000000000fff3
`define DVFC_CTLWORD_RESET 32'h0000000a
`define DVFC_CTLWORD_RMASK 32'h00000fff
`define DVFC_TMO_HI 31
`define DVFC_TMO_LO 12
`define DVFC_CHGMODE_BIT 11
`define DVFC_VCTL_BIT 10
`define DVFC_DCTL_HI 9
`define DVFC_DCTL_LO 8
`define DVFC_IDIV_HI 7
`define DVFC_IDIV_LO 5
`define DVFC_VOUT_HI 4
`define DVFC_VOUT_LO 0
`define DVFC_VID_RESET 5'h0a
`define DVFC_TMO_SCALE_LOG2 12
`define DVFC_MARKER_BE_N 8'hbf
`endif

/* shared/dvfc_pkg.sv */
// types of the voltage and frequency control block
package dvfc_pkg;
  typedef enum logic [2:0] {
    DVFC_IDLE = 3'h1,
    DVFC_MARK = 3'h2,
    DVFC_WAIT = 3'h4
  } dvfc_bus_e;
  typedef logic [31:0] dvfc_word_t;
endpackage : dvfc_pkg

/* rtl/dvfc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module dvfc_sync #(
  parameter int W = 1
) (
  sys_clk,
  rstn,
  asyncIn,
  syncOut
);
  input wire logic sys_clk;
  input wire logic rstn;
  input wire logic [W-1:0] asyncIn;
  output logic [W-1:0] syncOut;
  logic [W-1:0] meta_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      syncOut <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule : dvfc_sync

/* rtl/dvfc_stop_timer.sv */
// stop-grant interval counter
`timescale 1ns/1ps
`include "dvfc_map.svh"
module dvfc_stop_timer #(
  parameter int TW = 20
) (
  sys_clk,
  rstn,
  load,
  loadValue,
  active
);
  localparam int CW = TW + `DVFC_TMO_SCALE_LOG2;
  input wire logic sys_clk;
  input wire logic rstn;
  input wire logic load;
  input wire logic [TW-1:0] loadValue;
  output logic active;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = {loadValue, {`DVFC_TMO_SCALE_LOG2{1'b0}}};
    end else if (count_reg != '0) begin
      count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  // looks at the next count so that the interval is exactly the loaded number of clocks
  assign active = (count_next != '0);
endmodule : dvfc_stop_timer

/* rtl/dvfc_core.sv */
// voltage and bus divisor control with power window decode and marker cycle
// Notes on behaviour
// - aligned dword access inside enabled window is serviced internally, no bus cycle.
// - non-dword or unaligned window accesses go out as ordinary I/O cycles.
// - reset clears window contents to zero except voltage output field 01010b.
// - window-control bits 63-16 and 3-2 always read zero.
// - window-control bits 15-4 are read/write window base address.
// - marker enable issues special cycle, byte enables BFh, A[4:3]=00b, per access made while no marker cycle is pending.
// - marker cycle drives data/code low, memory/IO low, write/read high, address zero.
// - with window disabled, window accesses pass to the host bus.
// - clearing window enable leaves window contents untouched.
// - whole window-control register resets to zero.
// - non-zero timeout field write enters stop-grant state.
// - stop-grant lasts timeout value times 4096 bus clocks.
// - with change mode 0, changes apply only at timeout-write entry; 1 reserved.
// - voltage control 0 keeps voltage pins; 1 loads voltage output field on entry.
// - divisor control 00 uses reset-sampled pins; 1x takes internal divisor on entry.
// - with divisor control 1x, effective divisor loads internal divisor on entry.
// - voltage output field drives pins on entry when voltage control is 1; resets to 01010b and driven then.
// - control word at bytes 11-8; bytes 15-12 and 7-0 read zero.
// - on timeout expiry the stop-grant state ends.
`timescale 1ns/1ps
`include "dvfc_map.svh"
module dvfc_core #(
  parameter int TW = 20
) (
  sys_clk,
  rstn,
  msrWrite,
  msrRead,
  msrAddr,
  msrWdata,
  msrRdata,
  msrHit,
  ioReq,
  ioWrite,
  ioAddr,
  ioByteEn,
  ioWdata,
  ioRdata,
  ioInternal,
  ioForward,
  divisor_select_pins,
  burst_ready_ack,
  markerStart,
  markerAddr,
  byte_enables_n,
  dataCode,
  memIo,
  writeRead,
  voltage_id_pins,
  effective_divisor,
  strapDivisor,
  stopGrant
);
  input wire logic sys_clk;
  input wire logic rstn;
  input wire logic msrWrite;
  input wire logic msrRead;
  input wire logic [31:0] msrAddr;
  input wire logic [63:0] msrWdata;
  output logic [63:0] msrRdata;
  output logic msrHit;
  input wire logic ioReq;
  input wire logic ioWrite;
  input wire logic [15:0] ioAddr;
  input wire logic [3:0] ioByteEn;
  input wire logic [31:0] ioWdata;
  output logic [31:0] ioRdata;
  output logic ioInternal;
  output logic ioForward;
  input wire logic [2:0] divisor_select_pins;
  input wire logic burst_ready_ack;
  output logic markerStart;
  output logic [31:3] markerAddr;
  output logic [7:0] byte_enables_n;
  output logic dataCode;
  output logic memIo;
  output logic writeRead;
  output logic [4:0] voltage_id_pins;
  output logic [2:0] effective_divisor;
  output logic [2:0] strapDivisor;
  output logic stopGrant;

  // ==========================================================
  // pin inputs
  logic [2:0] divSync;
  logic [0:0] ackSync;
  dvfc_sync #(.W(3)) u_divSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn(divisor_select_pins),
    .syncOut(divSync)
  );
  dvfc_sync #(.W(1)) u_ackSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn(burst_ready_ack),
    .syncOut(ackSync)
  );

  // ==========================================================
  // decode
  logic [63:0] winCtl_reg;
  logic [63:0] winCtl_next;
  logic [31:0] ctlWord_reg;
  logic [31:0] ctlWord_next;
  logic msrSel;
  logic inWindow;
  logic dwordOk;
  logic winHit;
  logic ctlHit;
  logic tmoLoad;
  assign msrSel = (msrAddr == `DVFC_WINCTL_ADDR);
  assign inWindow = (ioAddr[15:4] == winCtl_reg[`DVFC_WIN_BASE_HI:`DVFC_WIN_BASE_LO]);
  assign dwordOk = (ioAddr[1:0] == 2'h0) && (ioByteEn == 4'hf);
  assign winHit = ioReq && inWindow && winCtl_reg[`DVFC_ENABLE_BIT] && dwordOk;
  assign ctlHit = winHit && (ioAddr[3:0] == `DVFC_CTLWORD_OFS);
  // fields of the control word as it is being written
  logic [TW-1:0] tmoField;
  logic chgMode;
  logic vctlMode;
  logic [1:0] dctlMode;
  logic [2:0] idivField;
  logic [4:0] voutField;
  assign tmoField = ioWdata[`DVFC_TMO_HI:`DVFC_TMO_LO];
  assign chgMode = ioWdata[`DVFC_CHGMODE_BIT];
  assign vctlMode = ioWdata[`DVFC_VCTL_BIT];
  assign dctlMode = ioWdata[`DVFC_DCTL_HI:`DVFC_DCTL_LO];
  assign idivField = ioWdata[`DVFC_IDIV_HI:`DVFC_IDIV_LO];
  assign voutField = ioWdata[`DVFC_VOUT_HI:`DVFC_VOUT_LO];
  assign tmoLoad = ctlHit && ioWrite && (tmoField != '0);

  // ==========================================================
  // registers
  always_comb begin
    winCtl_next = winCtl_reg;
    ctlWord_next = ctlWord_reg;
    if (msrWrite && msrSel) begin
      winCtl_next = msrWdata & `DVFC_WINCTL_WMASK;
    end
    // window contents are kept whatever the enable bit does
    if (ctlHit && ioWrite) begin
      ctlWord_next = ioWdata & `DVFC_CTLWORD_RMASK;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      winCtl_reg <= `DVFC_WINCTL_RESET;
      ctlWord_reg <= `DVFC_CTLWORD_RESET;
    end else begin
      winCtl_reg <= winCtl_next;
      ctlWord_reg <= ctlWord_next;
    end
  end

  // ==========================================================
  // stop-grant timer
  logic timerActive;
  dvfc_stop_timer #(.TW(TW)) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(tmoLoad),
    .loadValue(tmoField),
    .active(timerActive)
  );

  // ==========================================================
  // voltage and divisor outputs
  logic [4:0] vid_next;
  logic [2:0] ediv_next;
  logic [1:0] strapAge_reg;
  logic [1:0] strapAge_next;
  logic [2:0] strap_next;
  logic [31:0] ioRdata_next;
  logic [63:0] msrRdata_next;
  logic msrHit_next;
  logic ioInternal_next;
  logic ioForward_next;
  logic stopGrant_next;
  always_comb begin
    vid_next = voltage_id_pins;
    ediv_next = effective_divisor;
    strap_next = strapDivisor;
    strapAge_next = strapAge_reg;
    // the synchroniser is cleared by reset, so the pins are valid only from its third edge
    if (strapAge_reg != 2'h3) begin
      strapAge_next = strapAge_reg + 2'h1;
      strap_next = divSync;
      ediv_next = divSync;
    end
    // only change mode 0 is defined; entry through timeout write applies values
    if (tmoLoad && !chgMode) begin
      if (vctlMode) begin
        vid_next = voutField;
      end
      if (dctlMode[1]) begin
        ediv_next = idivField;
      end else if (dctlMode == 2'h0) begin
        ediv_next = strapDivisor;
      end
    end
    ioRdata_next = ctlHit ? ctlWord_reg : 32'h00000000;
    msrRdata_next = msrSel ? winCtl_reg : 64'h0000000000000000;
    msrHit_next = (msrRead || msrWrite) && msrSel;
    ioInternal_next = winHit;
    ioForward_next = ioReq && !winHit;
    stopGrant_next = tmoLoad || timerActive;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      voltage_id_pins <= `DVFC_VID_RESET;
      effective_divisor <= 3'h0;
      strapDivisor <= 3'h0;
      strapAge_reg <= 2'h0;
      ioRdata <= 32'h00000000;
      msrRdata <= 64'h0000000000000000;
      msrHit <= 1'b0;
      ioInternal <= 1'b0;
      ioForward <= 1'b0;
      stopGrant <= 1'b0;
    end else begin
      voltage_id_pins <= vid_next;
      effective_divisor <= ediv_next;
      strapDivisor <= strap_next;
      strapAge_reg <= strapAge_next;
      ioRdata <= ioRdata_next;
      msrRdata <= msrRdata_next;
      msrHit <= msrHit_next;
      ioInternal <= ioInternal_next;
      ioForward <= ioForward_next;
      stopGrant <= stopGrant_next;
    end
  end

  // ==========================================================
  // marker special cycle
  dvfc_pkg::dvfc_bus_e bus_reg;
  dvfc_pkg::dvfc_bus_e bus_next;
  logic markerStart_next;
  logic [7:0] byteEn_next;
  logic dataCode_next;
  logic memIo_next;
  logic writeRead_next;
  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      dvfc_pkg::DVFC_IDLE: begin
        if (winHit && winCtl_reg[`DVFC_MARKER_BIT]) begin
          bus_next = dvfc_pkg::DVFC_MARK;
        end
      end
      dvfc_pkg::DVFC_MARK: begin
        bus_next = dvfc_pkg::DVFC_WAIT;
      end
      dvfc_pkg::DVFC_WAIT: begin
        if (ackSync[0]) begin
          bus_next = dvfc_pkg::DVFC_IDLE;
        end
      end
      default: begin
        bus_next = dvfc_pkg::DVFC_IDLE;
      end
    endcase
    markerStart_next = (bus_next == dvfc_pkg::DVFC_MARK);
    // the special-cycle encoding stands from the start of the cycle until it is acknowledged
    if (bus_next != dvfc_pkg::DVFC_IDLE) begin
      byteEn_next = `DVFC_MARKER_BE_N;
      dataCode_next = 1'b0;
      memIo_next = 1'b0;
      writeRead_next = 1'b1;
    end else begin
      byteEn_next = 8'hff;
      dataCode_next = 1'b1;
      memIo_next = 1'b1;
      writeRead_next = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_reg <= dvfc_pkg::DVFC_IDLE;
      markerStart <= 1'b0;
      markerAddr <= '0;
      byte_enables_n <= 8'hff;
      dataCode <= 1'b1;
      memIo <= 1'b1;
      writeRead <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      markerStart <= markerStart_next;
      markerAddr <= '0;
      byte_enables_n <= byteEn_next;
      dataCode <= dataCode_next;
      memIo <= memIo_next;
      writeRead <= writeRead_next;
    end
  end
endmodule : dvfc_core

/* verif/dvfc_core_properties.sv */
// assertion checker for the voltage and divisor control core
`timescale 1ns/1ps
`include "dvfc_map.svh"
module dvfc_core_properties #(
  parameter int TW = 20
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic msrWrite,
  input wire logic [31:0] msrAddr,
  input wire logic [63:0] msrWdata,
  input wire logic ioReq,
  input wire logic [15:0] ioAddr,
  input wire logic [3:0] ioByteEn,
  input wire logic ioInternal,
  input wire logic ioForward,
  input wire logic burst_ready_ack,
  input wire logic markerStart,
  input wire logic [31:3] markerAddr,
  input wire logic [7:0] byte_enables_n,
  input wire logic dataCode,
  input wire logic memIo,
  input wire logic writeRead,
  input wire logic stopGrant
);
  // ==========
  // shadow of the window control register
  logic [63:0] win_reg;
  logic [63:0] win_next;
  logic winHit;
  always_comb begin
    win_next = win_reg;
    if (msrWrite && msrAddr == `DVFC_WINCTL_ADDR) begin
      win_next = msrWdata & `DVFC_WINCTL_WMASK;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) win_reg <= '0;
    else win_reg <= win_next;
  end
  assign winHit = ioReq && ioByteEn == 4'hf && ioAddr[1:0] == 2'h0 && win_reg[0]
    && ioAddr[15:4] == win_reg[15:4];
  // ==========
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_window_hit: assert property (winHit |=> ioInternal && !ioForward)
    else $error("window access not serviced inside");
  a_odd_forward: assert property (ioReq && ioByteEn != 4'hf |=> ioForward && !ioInternal)
    else $error("partial access not forwarded");
  a_disabled_pass: assert property (ioReq && !win_reg[0] |=> ioForward)
    else $error("disabled window access not forwarded");
  a_marker_issue: assert property (winHit && win_reg[1] && !writeRead |=> markerStart)
    else $error("marker cycle missing");
  a_marker_lanes: assert property (markerStart |-> byte_enables_n == `DVFC_MARKER_BE_N)
    else $error("marker byte lanes wrong");
  a_marker_kind: assert property (markerStart |-> !dataCode && !memIo && writeRead)
    else $error("marker cycle kind wrong");
  a_marker_addr: assert property (writeRead |-> markerAddr == '0)
    else $error("marker address not zero");
  a_marker_hold: assert property (writeRead && !burst_ready_ack |=> writeRead)
    else $error("marker ended without acknowledge");
  a_ack_ends: assert property ($rose(burst_ready_ack) && writeRead |-> ##[1:4] !writeRead)
    else $error("marker not ended after acknowledge");
  a_stop_entry: assert property ($rose(stopGrant) |-> ioInternal)
    else $error("stop state entered without write");
  c_marker: cover property (markerStart);
  c_stop_end: cover property ($fell(stopGrant));
  c_forward: cover property (ioForward);
endmodule : dvfc_core_properties

/* verif/dvfc_host_model.sv */
// host system logic answering marker special cycles
`timescale 1ns/1ps
module dvfc_host_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slowAck,
  input wire logic writeRead,
  output logic burst_ready_ack
);
  logic [3:0] wait_reg;
  // acknowledge every marker cycle and hold it until the cycle closes
  // no inquire cycle is ever started from here
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 4'h0;
      burst_ready_ack <= 1'b0;
    end else if (!writeRead) begin
      wait_reg <= 4'h0;
      burst_ready_ack <= 1'b0;
    end else if (wait_reg == (slowAck ? 4'h6 : 4'h1)) begin
      burst_ready_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : dvfc_host_model

/* verif/test_dynamic_voltage_freq_control.sv */
// self-checking bench for the voltage and divisor control core
`timescale 1ns/1ps
`include "dvfc_map.svh"
module test_dynamic_voltage_freq_control;
  localparam logic [31:0] WinAddr = `DVFC_WINCTL_ADDR;
  logic sys_clk, rstn, msrWrite, msrRead, msrHit, ioReq, ioWrite, ioInternal, ioForward;
  logic burst_ready_ack, slowAck, markerStart, dataCode, memIo, writeRead, stopGrant;
  logic [31:0] msrAddr, ioWdata, ioRdata;
  logic [63:0] msrWdata, msrRdata;
  logic [15:0] ioAddr;
  logic [3:0] ioByteEn;
  logic [2:0] divisor_select_pins, effective_divisor, strapDivisor;
  logic [31:3] markerAddr;
  logic [7:0] byte_enables_n;
  logic [4:0] voltage_id_pins;
  int n_mismatch = 0;
  int n_tests = 0;
  dvfc_core #(.TW(20)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .msrWrite(msrWrite),
    .msrRead(msrRead), .msrAddr(msrAddr), .msrWdata(msrWdata), .msrRdata(msrRdata),
    .msrHit(msrHit), .ioReq(ioReq), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioByteEn(ioByteEn),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .ioInternal(ioInternal), .ioForward(ioForward),
    .divisor_select_pins(divisor_select_pins), .burst_ready_ack(burst_ready_ack),
    .markerStart(markerStart), .markerAddr(markerAddr), .byte_enables_n(byte_enables_n),
    .dataCode(dataCode), .memIo(memIo), .writeRead(writeRead),
    .voltage_id_pins(voltage_id_pins), .effective_divisor(effective_divisor),
    .strapDivisor(strapDivisor), .stopGrant(stopGrant));
  dvfc_host_model host_u (.sys_clk(sys_clk), .rstn(rstn), .slowAck(slowAck),
    .writeRead(writeRead), .burst_ready_ack(burst_ready_ack));
  always #10 sys_clk = ~sys_clk;
  // ==========
  // bus tasks, compare and verdict
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic msr(input logic wr, input logic [31:0] a, input logic [63:0] d);
    @(negedge sys_clk);
    msrWrite = wr;
    msrRead = !wr;
    msrAddr = a;
    msrWdata = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    msrWrite = 1'b0;
    msrRead = 1'b0;
  endtask : msr
  task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(negedge sys_clk);
    ioReq = 1'b1;
    ioWrite = wr;
    ioAddr = a;
    ioByteEn = be;
    ioWdata = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    ioReq = 1'b0;
  endtask : io
  task automatic stop_run(input logic [31:0] w, output int n);
    n = 0;
    io(1'b1, 16'h1208, 4'hf, w);
    while (stopGrant === 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : stop_run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ==========
  // scenarios
  task automatic t_reset;
    chk("vid", 5'h0a, voltage_id_pins);
    chk("divisor", 3'h6, effective_divisor);
    chk("strap", 3'h6, strapDivisor);
    msr(1'b0, WinAddr, '0);
    chk("window ctl", '0, msrRdata);
    msr(1'b1, WinAddr, 64'h1201);
    io(1'b0, 16'h1208, 4'hf, '0);
    chk("control word", 32'h0a, ioRdata);
    chk("internal", 1'b1, ioInternal);
    $display("reset test done");
  endtask : t_reset
  task automatic t_msr;
    msr(1'b1, WinAddr, '1);
    msr(1'b0, WinAddr, '0);
    chk("window ctl", 64'hfff3, msrRdata);
    chk("hit", 1'b1, msrHit);
    msr(1'b0, 32'hc0000087, '0);
    chk("miss hit", 1'b0, msrHit);
    msr(1'b1, WinAddr, 64'h1201);
    $display("register test done");
  endtask : t_msr
  task automatic t_decode;
    for (int k = 0; k < 4; k++) io(1'b1, 16'h1200 + 16'(k * 4), 4'hf, 32'h3ff);
    for (int k = 0; k < 4; k++) begin
      io(1'b0, 16'h1200 + 16'(k * 4), 4'hf, '0);
      chk("block byte", (k == 2) ? 32'h3ff : 32'h0, ioRdata);
    end
    io(1'b0, 16'h1209, 4'hf, '0);
    chk("unaligned", 2'b01, {ioInternal, ioForward});
    io(1'b0, 16'h1208, 4'h3, '0);
    chk("partial", 2'b01, {ioInternal, ioForward});
    msr(1'b1, WinAddr, 64'h1200);
    io(1'b0, 16'h1208, 4'hf, '0);
    chk("disabled", 2'b01, {ioInternal, ioForward});
    msr(1'b1, WinAddr, 64'h1201);
    io(1'b0, 16'h1208, 4'hf, '0);
    chk("kept word", 32'h3ff, ioRdata);
    $display("decode test done");
  endtask : t_decode
  task automatic t_stop;
    int n;
    stop_run(32'h26b3, n);
    chk("stop span", 32'd8192, n);
    chk("vid", 5'h13, voltage_id_pins);
    chk("divisor", 3'h5, effective_divisor);
    stop_run(32'h1025, n);
    chk("stop span", 32'd4096, n);
    chk("vid kept", 5'h13, voltage_id_pins);
    chk("strap divisor", 3'h6, effective_divisor);
    stop_run(32'h1e1f, n);
    chk("reserved mode span", 32'd4096, n);
    chk("reserved mode vid", 5'h13, voltage_id_pins);
    chk("reserved mode divisor", 3'h6, effective_divisor);
    stop_run(32'h41f, n);
    chk("no stop", 32'd0, n);
    chk("vid idle", 5'h13, voltage_id_pins);
    $display("stop test done");
  endtask : t_stop
  task automatic t_marker;
    int n;
    msr(1'b1, WinAddr, 64'h1203);
    for (int s = 0; s < 2; s++) begin
      slowAck = s[0];
      io(1'b0, 16'h1208, 4'hf, '0);
      chk("marker start", 1'b1, markerStart);
      chk("marker lanes", 8'hbf, byte_enables_n);
      chk("marker kind", 3'b001, {dataCode, memIo, writeRead});
      chk("marker addr", '0, markerAddr);
      n = 0;
      while (writeRead === 1'b1 && n < 30) begin
        @(negedge sys_clk);
        n++;
      end
      chk("idle lanes", 8'hff, byte_enables_n);
    end
    msr(1'b1, WinAddr, 64'h1200);
    $display("marker test done");
  endtask : t_marker
  initial begin
    {sys_clk, rstn, msrWrite, msrRead, ioReq, ioWrite, slowAck} = '0;
    {msrAddr, msrWdata, ioAddr, ioByteEn, ioWdata} = '0;
    divisor_select_pins = 3'h6;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_msr;
    t_decode;
    t_stop;
    t_marker;
    conclude;
  end
  initial begin
    #600000;
    n_mismatch++;
    conclude;
  end
endmodule : test_dynamic_voltage_freq_control
bind dvfc_core dvfc_core_properties #(.TW(TW)) props_u (.sys_clk(sys_clk), .rstn(rstn),
  .msrWrite(msrWrite), .msrAddr(msrAddr), .msrWdata(msrWdata), .ioReq(ioReq),
  .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioInternal(ioInternal), .ioForward(ioForward),
  .burst_ready_ack(burst_ready_ack), .markerStart(markerStart), .markerAddr(markerAddr),
  .byte_enables_n(byte_enables_n), .dataCode(dataCode), .memIo(memIo),
  .writeRead(writeRead), .stopGrant(stopGrant));
